// ==== verilog/status_io_pkg.sv ====
`default_nettype none
package status_io_pkg;

  // ==========================================================================
  // sizes
  localparam int NUM_PINS   = 2;
  localparam int PWM_WIDTH  = 24;
  localparam int CTRL_WIDTH = 5;
  localparam int ADDR_WIDTH = 8;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL0   = 8'h00;
  localparam logic [7:0] ADDR_CTRL1   = 8'h04;
  localparam logic [7:0] ADDR_PERIOD0 = 8'h08;
  localparam logic [7:0] ADDR_LOW0    = 8'h0c;
  localparam logic [7:0] ADDR_PERIOD1 = 8'h10;
  localparam logic [7:0] ADDR_LOW1    = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;

  // ==========================================================================
  // control field layout
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_INVERT_BIT = 2;
  localparam int CTRL_SRC_LSB    = 3;

  // pin function codes
  localparam logic [1:0] MODE_INDICATOR = 2'h0;
  localparam logic [1:0] MODE_INPUT     = 2'h1;
  localparam logic [1:0] MODE_OUTPUT    = 2'h2;

  // output source codes
  localparam logic [1:0] SRC_TRUE  = 2'h0;
  localparam logic [1:0] SRC_FALSE = 2'h1;
  localparam logic [1:0] SRC_PWM   = 2'h2;

  // status field layout
  localparam int STATUS_INPUT_LSB = 0;
  localparam int STATUS_PIN_LSB   = 2;

  // ==========================================================================
  // reset values: 100 Hz, 10 % low at 40 MHz
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET   = 5'h00;
  localparam logic [PWM_WIDTH-1:0]  PERIOD_RESET = 24'h061a80;
  localparam logic [PWM_WIDTH-1:0]  LOW_RESET    = 24'h009c40;

endpackage
`default_nettype wire

// ==== verilog/status_digital_io_pins.sv ====
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module status_digital_io_pins
  import status_io_pkg::*;
#(
  parameter int PINS = NUM_PINS,
  parameter int PW   = PWM_WIDTH
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic                  protection_active,
  input  wire logic                  main_output_on,
  input  wire logic [1:0]            pin_in,
  output var  logic [1:0]            pin_out,
  output var  logic [1:0]            pin_oe_n,
  output var  logic [1:0]            input_state
);

  // ==========================================================================
  // configuration
  logic [CTRL_WIDTH-1:0] ctrl       [2];
  logic [PW-1:0]         pwm_period [2];
  logic [PW-1:0]         pwm_low    [2];
  logic [PW-1:0]         pwm_count  [2];

  logic        access;
  logic        wr_en;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [1:0]  next_pin_out;
  logic [1:0]  next_pin_oe_n;
  logic [1:0]  pwm_low_phase;

  // ==========================================================================
  // field decoding
  function automatic logic [1:0] mode_of(input logic [CTRL_WIDTH-1:0] c);
    return c[CTRL_MODE_LSB+:2];
  endfunction

  function automatic logic [1:0] src_of(input logic [CTRL_WIDTH-1:0] c);
    return c[CTRL_SRC_LSB+:2];
  endfunction

  function automatic logic inv_of(input logic [CTRL_WIDTH-1:0] c);
    return c[CTRL_INVERT_BIT];
  endfunction

  // level before inversion; a driven 1 goes out low, a 0 high
  function automatic logic pin_base(input logic [1:0] mode,
                                    input logic [1:0] src,
                                    input logic       ind_level,
                                    input logic       low_phase);
    logic lvl;
    lvl = 1'b1;
    case (mode)
      MODE_OUTPUT: begin
        case (src)
          SRC_TRUE:  lvl = 1'b0;
          SRC_FALSE: lvl = 1'b1;
          SRC_PWM:   lvl = ~low_phase;
          default:   lvl = 1'b1;
        endcase
      end
      MODE_INPUT: lvl = 1'b1;
      default:    lvl = ind_level;
    endcase
    return lvl;
  endfunction

  // ==========================================================================
  // apb slave: one wait state, so every answer comes from a flop
  assign access = psel & penable;
  assign wr_en  = access & pready & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access & ~pready) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end
  end

  // an error answer stands only in its ready cycle, never after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= access & ~pready & next_pslverr;
    end
  end

  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      ADDR_CTRL0:   next_prdata[CTRL_WIDTH-1:0] = ctrl[0];
      ADDR_CTRL1:   next_prdata[CTRL_WIDTH-1:0] = ctrl[1];
      ADDR_PERIOD0: next_prdata[PW-1:0] = pwm_period[0];
      ADDR_LOW0:    next_prdata[PW-1:0] = pwm_low[0];
      ADDR_PERIOD1: next_prdata[PW-1:0] = pwm_period[1];
      ADDR_LOW1:    next_prdata[PW-1:0] = pwm_low[1];
      ADDR_STATUS: begin
        next_prdata[STATUS_INPUT_LSB+:2] = input_state;
        next_prdata[STATUS_PIN_LSB+:2]   = pin_out;
      end
      default: next_pslverr = 1'b1;
    endcase
  end

  // ==========================================================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        ctrl[i]       <= CTRL_RESET;
        pwm_period[i] <= PERIOD_RESET;
        pwm_low[i]    <= LOW_RESET;
      end
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL0:   ctrl[0] <= pwdata[CTRL_WIDTH-1:0];
        ADDR_CTRL1:   ctrl[1] <= pwdata[CTRL_WIDTH-1:0];
        ADDR_PERIOD0: pwm_period[0] <= pwdata[PW-1:0];
        ADDR_LOW0:    pwm_low[0] <= pwdata[PW-1:0];
        ADDR_PERIOD1: pwm_period[1] <= pwdata[PW-1:0];
        ADDR_LOW1:    pwm_low[1] <= pwdata[PW-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // pwm counters: a period of 0 or 1 just holds the counter at 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        pwm_count[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pwm_count[i] + PW'(1) >= pwm_period[i]) begin
          pwm_count[i] <= '0;
        end else begin
          pwm_count[i] <= pwm_count[i] + PW'(1);
        end
      end
    end
  end

  // a nonzero low setting at or above the period keeps the pin in its low phase
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pwm_low_phase[i] = pwm_count[i] < pwm_low[i];
    end
  end

  // ==========================================================================
  // pin drive
  always_comb begin
    next_pin_out[0] = pin_base(mode_of(ctrl[0]),
                               src_of(ctrl[0]),
                               ~protection_active,
                               pwm_low_phase[0])
                      ^ inv_of(ctrl[0]);
    next_pin_out[1] = pin_base(mode_of(ctrl[1]),
                               src_of(ctrl[1]),
                               ~main_output_on,
                               pwm_low_phase[1])
                      ^ inv_of(ctrl[1]);
    for (int i = 0; i < 2; i++) begin
      // input mode releases the pin for the outside driver
      next_pin_oe_n[i] = (mode_of(ctrl[i]) == MODE_INPUT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out  <= 2'h3;
      pin_oe_n <= 2'h0;
    end else begin
      pin_out  <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  // ==========================================================================
  // input sampling; polarity applies to inputs too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_state <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        input_state[i] <= pin_in[i] ^ inv_of(ctrl[i]);
      end
    end
  end

endmodule
`default_nettype wire

// ==== bench/ext_io_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// far-side instrument: applies its level only while the device lets go
module ext_io_model (
  input  wire logic [1:0] drive_level,
  input  wire logic [1:0] pin_oe_n,
  input  wire logic [1:0] pin_out,
  output logic      [1:0] pin_wire
);
  assign pin_wire = (pin_oe_n & drive_level) | (~pin_oe_n & pin_out);
endmodule
`default_nettype wire

// ==== bench/status_io_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module status_io_chk
  import status_io_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        protection_active,
  input wire logic        main_output_on,
  input wire logic [1:0]  pin_in,
  input wire logic [1:0]  pin_out,
  input wire logic [1:0]  pin_oe_n,
  input wire logic [1:0]  input_state
);
  // ==========================================================================
  // indicator checks only hold until software rewrites a control word
  logic d0;
  logic d1;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d0 <= 1'b0;
      d1 <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      d0 <= d0 | (paddr == ADDR_CTRL0);
      d1 <= d1 | (paddr == ADDR_CTRL1);
    end
  end
  a_prot_ind: assert property ($past(presetn) && !d0 |->
    pin_out[0] == !$past(protection_active)) else $error("pin0 level");
  a_off_ind: assert property ($past(presetn) && !d1 |->
    pin_out[1] == !$past(main_output_on)) else $error("pin1 level");
  a_ind_drv: assert property (!d0 && !d1 |-> pin_oe_n == 2'h0)
    else $error("indicator undriven");
  a_in_samp0: assert property (pin_oe_n[0] |->
    input_state[0] == ($past(pin_in[0]) ^ !pin_out[0])) else $error("in0");
  a_in_samp1: assert property (pin_oe_n[1] |->
    input_state[1] == ($past(pin_in[1]) ^ !pin_out[1])) else $error("in1");
  a_rdy_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  a_wait_one: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("ready timing");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error reply");
endmodule
bind status_digital_io_pins status_io_chk chk_i (
  .pclk              (pclk),
  .presetn           (presetn),
  .psel              (psel),
  .penable           (penable),
  .pwrite            (pwrite),
  .paddr             (paddr),
  .pwdata            (pwdata),
  .prdata            (prdata),
  .pready            (pready),
  .pslverr           (pslverr),
  .protection_active (protection_active),
  .main_output_on    (main_output_on),
  .pin_in            (pin_in),
  .pin_out           (pin_out),
  .pin_oe_n          (pin_oe_n),
  .input_state       (input_state)
);
`default_nettype wire

// ==== bench/status_digital_io_pins_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module status_digital_io_pins_tb;
  import status_io_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        protection_active = 0, main_output_on = 0, pready, pslverr, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  pin_in, pin_out, pin_oe_n, input_state;
  logic [1:0]  ext_lvl = 2'h0;
  int          error_cnt = 0, checked = 0;
  always #12.5 pclk = ~pclk;
  status_digital_io_pins DUT (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .protection_active (protection_active),
    .main_output_on    (main_output_on),
    .pin_in            (pin_in),
    .pin_out           (pin_out),
    .pin_oe_n          (pin_oe_n),
    .input_state       (input_state)
  );
  ext_io_model far (.drive_level(ext_lvl), .pin_oe_n(pin_oe_n),
                    .pin_out(pin_out), .pin_wire(pin_in));
  // ==========================================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count is assumed; only the watchdog ends a hung transfer
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic both(input logic [31:0] c);
    apb(1'b1, ADDR_CTRL0, c);
    apb(1'b1, ADDR_CTRL1, c);
    repeat (2) @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_err();
    apb(1'b0, 8'h1c, 32'h0);
    chk("pslverr", er, 1);
    chk("prdata", rd, 0);
    apb(1'b0, ADDR_PERIOD1, 32'h0);
    chk("period1", rd, PERIOD_RESET);
    $display("register test done");
  endtask
  task automatic t_ind();
    for (int i = 0; i < 8; i++) begin
      if (i == 4) both(32'h4);
      protection_active <= i[0];
      main_output_on <= i[1];
      repeat (2) @(posedge pclk);
      chk("pin_out", pin_out, {~i[1], ~i[0]} ^ {2{i[2]}});
    end
    $display("indicator test done");
  endtask
  task automatic t_out();
    for (int s = 0; s < 2; s++)
      for (int v = 0; v < 2; v++) begin
        both(32'({s[1:0], v[0], MODE_OUTPUT}));
        chk("pin_out", pin_out, {2{s[0] ^ v[0]}});
        chk("pin_oe_n", pin_oe_n, 0);
      end
    both(32'h1a);
    chk("pin_out src3", pin_out, 3);
    both(32'h3);
    chk("pin_out mode3", pin_out, {~main_output_on, ~protection_active});
    $display("output test done");
  endtask
  task automatic t_in();
    for (int v = 0; v < 2; v++) begin
      both(32'({v[0], MODE_INPUT}));
      for (int e = 0; e < 4; e++) begin
        ext_lvl <= e[1:0];
        repeat (2) @(posedge pclk);
        chk("input_state", input_state, e[1:0] ^ {2{v[0]}});
        chk("pin_oe_n", pin_oe_n, 3);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status", rd[1:0], e[1:0] ^ {2{v[0]}});
        chk("status pins", rd[3:2], {2{~v[0]}});
      end
    end
    $display("input test done");
  endtask
  task automatic t_pwm();
    int n0;
    int n1;
    apb(1'b1, ADDR_PERIOD0, 32'd10);
    apb(1'b1, ADDR_LOW0, 32'd3);
    apb(1'b1, ADDR_PERIOD1, 32'd8);
    apb(1'b1, ADDR_LOW1, 32'd5);
    for (int v = 0; v < 2; v++) begin
      both(32'({SRC_PWM, v[0], MODE_OUTPUT}));
      n0 = 0;
      n1 = 0;
      // whole periods of both pins, so the counter phase does not matter
      repeat (40) begin
        @(posedge pclk);
        n0 += (pin_out[0] === 1'b0);
        n1 += (pin_out[1] === 1'b0);
      end
      chk("low cycles 0", n0, v ? 28 : 12);
      chk("low cycles 1", n1, v ? 15 : 25);
    end
    $display("pwm test done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_err();
    t_ind();
    t_out();
    t_in();
    t_pwm();
    give_verdict();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
